// File: rtl/umc_pkg.sv
// Constants and types for the USB high-speed boost mode control block
package umc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int DIS_MIN_US     = 100;
  localparam int READY_MAX_US   = 500;
  // Least time rounds up, longest time rounds down
  localparam int DIS_MIN_CYC    = (DIS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_MAX_CYC  = (READY_MAX_US * 1000) / CLK_PERIOD_NS;
  // Settle after release before detection restarts; well inside the ready bound
  localparam int SETTLE_CYC     = 16;
  localparam int CNT_W          = 13;
  localparam int LVL_W          = 2;
  localparam logic [LVL_W-1:0] LVL_RST = 2'h0;

  // ---------------------------------------------------------------------------
  // Modes, Gray coded along the usual path
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    UMC_SHUTDOWN = 3'h0,
    UMC_SETTLE   = 3'h1,
    UMC_IDLE     = 3'h3,
    UMC_LOWFULL  = 3'h2,
    UMC_HIGH     = 3'h6,
    UMC_EYETEST  = 3'h7
  } umc_mode_t;

  typedef struct packed {
    umc_mode_t         mode;
    logic [CNT_W-1:0]  cnt;
    logic [LVL_W-1:0]  level;
    logic              was_high;
    logic              det;
    logic              boost;
    logic              boost_en;
  } umc_state_t;

endpackage : umc_pkg

// File: rtl/umc_mode_ctrl.sv
// Mode detection and status outputs of the high-speed boost conditioner
`timescale 1ns/1ps
`default_nettype none
module umc_mode_ctrl #(
  parameter int DIS_MIN_CYC = umc_pkg::DIS_MIN_CYC   // Valid disable width in cycles
) (
  input  wire logic                        clk,                   // 10 MHz clock
  input  wire logic                        rst,                   // Sync reset, active high
  input  wire logic                        chip_disable_n,        // Disable, active low
  input  wire logic [umc_pkg::LVL_W-1:0]   boost_level_strap,     // Decoded strap level
  input  wire logic                        ls_detect,             // Low-speed link seen
  input  wire logic                        fs_detect,             // Full-speed link seen
  input  wire logic                        hs_detect,             // High-speed link seen
  input  wire logic                        fixture_detect,        // Compliance fixture seen
  input  wire logic                        disconnect,            // Link went idle
  output logic                             connection_detect_out, // Connection status
  output logic                             hs_boost_active_out,   // Boost status
  output logic                             boost_enable,          // Boost on, both directions
  output logic [umc_pkg::LVL_W-1:0]        boost_level,           // Latched boost level
  output logic                             ready                  // Settled after release
);

  umc_pkg::umc_state_t s_reg;
  umc_pkg::umc_state_t s_next;
  logic                dis_valid;

  // A disable shorter than the minimum width is treated as a glitch
  // Counter saturates, so a very long disable never wraps back into a glitch
  assign dis_valid = (s_reg.cnt >= umc_pkg::CNT_W'(DIS_MIN_CYC));

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Mode moves first; the disable override and the status pairs follow,
    // so the registered outputs always match the mode held next
    case (s_reg.mode)
      umc_pkg::UMC_SHUTDOWN: begin
        if (!chip_disable_n) begin
          if (s_reg.cnt != {umc_pkg::CNT_W{1'b1}}) begin
            s_next.cnt = s_reg.cnt + 1'b1;
          end
        end else if (dis_valid) begin
          // Release: relatch strap, drop speed, keep only high-speed history
          s_next.level = boost_level_strap;
          s_next.cnt   = '0;
          s_next.mode  = umc_pkg::UMC_SETTLE;
        end else begin
          // Too short a pulse: resume where we were, strap untouched
          // Low/full speed and eye test fall back to idle and rediscover the link
          s_next.cnt  = '0;
          s_next.mode = s_reg.was_high ? umc_pkg::UMC_HIGH : umc_pkg::UMC_IDLE;
        end
      end
      umc_pkg::UMC_SETTLE: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == umc_pkg::CNT_W'(umc_pkg::SETTLE_CYC - 1)) begin
          s_next.cnt  = '0;
          // Toggle seen while in high speed goes straight to eye
          s_next.mode = s_reg.was_high ? umc_pkg::UMC_EYETEST : umc_pkg::UMC_IDLE;
          s_next.was_high = 1'b0;
        end
      end
      umc_pkg::UMC_IDLE: begin
        if (fixture_detect) begin
          s_next.mode = umc_pkg::UMC_EYETEST;
        end else if (hs_detect) begin
          s_next.mode = umc_pkg::UMC_HIGH;
        end else if (ls_detect || fs_detect) begin
          s_next.mode = umc_pkg::UMC_LOWFULL;
        end
      end
      umc_pkg::UMC_LOWFULL: begin
        if (disconnect) begin
          s_next.mode = umc_pkg::UMC_IDLE;
        end else if (hs_detect) begin
          s_next.mode = umc_pkg::UMC_HIGH;
        end
      end
      umc_pkg::UMC_HIGH: begin
        if (disconnect) begin
          s_next.mode = umc_pkg::UMC_IDLE;
        end
      end
      umc_pkg::UMC_EYETEST: begin
        if (disconnect) begin
          s_next.mode = umc_pkg::UMC_IDLE;
        end
      end
      default: begin
        s_next.mode = umc_pkg::UMC_IDLE;
      end
    endcase
    // Disable low overrides every mode
    if (!chip_disable_n && s_reg.mode != umc_pkg::UMC_SHUTDOWN) begin
      s_next.mode     = umc_pkg::UMC_SHUTDOWN;
      s_next.cnt      = umc_pkg::CNT_W'(1);
      s_next.was_high = (s_reg.mode == umc_pkg::UMC_HIGH);
    end
    // Status pairs per mode; eye test is the only detect-low boost-high pair
    case (s_next.mode)
      umc_pkg::UMC_LOWFULL: begin
        s_next.det   = 1'b1;
        s_next.boost = 1'b0;
      end
      umc_pkg::UMC_HIGH: begin
        s_next.det   = 1'b1;
        s_next.boost = 1'b1;
      end
      umc_pkg::UMC_EYETEST: begin
        s_next.det   = 1'b0;
        s_next.boost = 1'b1;
      end
      default: begin
        s_next.det   = 1'b0;
        s_next.boost = 1'b0;
      end
    endcase
    s_next.boost_en = s_next.boost;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.mode     <= umc_pkg::UMC_SHUTDOWN;
      // Saturated count makes the first release after reset a valid one,
      // so the strap is sampled at power-up as well
      s_reg.cnt      <= '1;
      s_reg.level    <= umc_pkg::LVL_RST;
      s_reg.was_high <= 1'b0;
      s_reg.det      <= 1'b0;
      s_reg.boost    <= 1'b0;
      s_reg.boost_en <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // One enable for both directions, so a role swap needs no steering
  assign boost_enable          = s_reg.boost_en;
  assign boost_level           = s_reg.level;
  assign connection_detect_out = s_reg.det;
  assign hs_boost_active_out   = s_reg.boost;
  // Ready is a handshake level, decoded straight from the mode register
  assign ready = (s_reg.mode != umc_pkg::UMC_SHUTDOWN) && (s_reg.mode != umc_pkg::UMC_SETTLE);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_shutdown_quiet: assert property (@(posedge clk) disable iff (rst)
    !chip_disable_n |=> !connection_detect_out && !hs_boost_active_out && !boost_enable)
    else $error("outputs active while disabled");
  a_lowfull_pair: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_IDLE && chip_disable_n && !fixture_detect && !hs_detect
      && (ls_detect || fs_detect) |=> connection_detect_out && !hs_boost_active_out)
    else $error("low or full speed status wrong");
  a_fs_noboost: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_LOWFULL
      |-> connection_detect_out && !hs_boost_active_out && !boost_enable)
    else $error("boost on in full speed");
  a_hs_boost: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_IDLE && chip_disable_n && !fixture_detect && hs_detect
      |=> boost_enable && connection_detect_out && hs_boost_active_out)
    else $error("high speed did not boost");
  a_boost_pair: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_HIGH
      |-> boost_enable && connection_detect_out && hs_boost_active_out)
    else $error("status and boost disagree");
  a_fixture_eye: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_IDLE && chip_disable_n && fixture_detect
      |=> !connection_detect_out && hs_boost_active_out && boost_enable)
    else $error("fixture did not enter eye test");
  a_eye_distinct: assert property (@(posedge clk) disable iff (rst)
    !connection_detect_out && hs_boost_active_out |-> s_reg.mode == umc_pkg::UMC_EYETEST)
    else $error("eye test pair seen outside eye test");
  a_eye_holds: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_EYETEST && chip_disable_n && !disconnect
      |=> !connection_detect_out && hs_boost_active_out)
    else $error("eye test left without cause");

  // ---------------------------------------------------------------------------
  // Checks on the disable and release path
  // ---------------------------------------------------------------------------
  a_hs_history: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_HIGH && !chip_disable_n |=> s_reg.was_high)
    else $error("high speed history lost on disable");
  a_toggle_eye: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SETTLE && s_reg.was_high && chip_disable_n
      && s_reg.cnt == umc_pkg::CNT_W'(umc_pkg::SETTLE_CYC - 1)
      |=> !connection_detect_out && hs_boost_active_out && boost_enable)
    else $error("toggle in high speed missed eye test");
  a_strap_hold: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode != umc_pkg::UMC_SHUTDOWN |=> $stable(boost_level))
    else $error("strap level changed outside release");
  a_relatch_strap: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SHUTDOWN && chip_disable_n && dis_valid
      |=> s_reg.mode == umc_pkg::UMC_SETTLE && boost_level == $past(boost_level_strap))
    else $error("release did not relatch strap");
  a_short_keep: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SHUTDOWN && chip_disable_n && !dis_valid
      |=> $stable(boost_level))
    else $error("short disable relatched strap");
  a_disable_count: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SHUTDOWN && !chip_disable_n && !dis_valid
      |=> s_reg.cnt == $past(s_reg.cnt) + 1'b1)
    else $error("disable width not counted");
  a_settle_quiet: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SETTLE
      |-> !connection_detect_out && !hs_boost_active_out && !boost_enable)
    else $error("status shown while settling");
  a_settle_ready: assert property (@(posedge clk) disable iff (rst)
    s_reg.mode == umc_pkg::UMC_SETTLE |-> ##[1:16] (ready || !chip_disable_n))
    else $error("settle took too long");
  a_ready_bound: assert property (@(posedge clk) disable iff (rst)
    $rose(chip_disable_n) && s_reg.cnt >= umc_pkg::CNT_W'(DIS_MIN_CYC)
      |-> ##[1:20] (ready || !chip_disable_n))
    else $error("not ready in time after release");

endmodule // umc_mode_ctrl
`default_nettype wire

// File: test/umc_link_model.sv
// Link-side model: presents one line-sensing event at a time to the mode control
`timescale 1ns/1ps
`default_nettype none
module umc_link_model (
  input  wire logic [2:0] kind,           // 0 quiet, 1 ls, 2 fs, 3 hs, 4 fixture, 5 unplug
  output logic            ls_detect,      // Low-speed signalling seen
  output logic            fs_detect,      // Full-speed signalling seen
  output logic            hs_detect,      // High-speed chirp seen
  output logic            fixture_detect, // Compliance fixture seen
  output logic            disconnect      // Line gone idle
);
  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  // Same sensing whichever end is host, so no role input exists
  always_comb begin
    ls_detect      = (kind == 3'h1);
    fs_detect      = (kind == 3'h2);
    hs_detect      = (kind == 3'h3);
    fixture_detect = (kind == 3'h4);
    disconnect     = (kind == 3'h5);
  end
endmodule // umc_link_model
`default_nettype wire

// File: test/umc_mode_ctrl_bench.sv
// Self-checking bench for the boost mode control
`timescale 1ns/1ps
`default_nettype none
module umc_mode_ctrl_bench;
  localparam int DIS_CYC = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       chip_disable_n = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [2:0] kind = 3'h0;
  wire logic  ls, fs, hs, fx, dc, cd, hsb, ben, rdy;
  wire logic [1:0] lvl;
  wire logic [3:0] stat = {1'b0, cd, hsb, ben};
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int w;

  umc_link_model link_i (.kind(kind), .ls_detect(ls), .fs_detect(fs), .hs_detect(hs),
    .fixture_detect(fx), .disconnect(dc));
  umc_mode_ctrl #(.DIS_MIN_CYC(DIS_CYC)) uut (.clk(clk), .rst(rst),
    .chip_disable_n(chip_disable_n), .boost_level_strap(strap), .ls_detect(ls),
    .fs_detect(fs), .hs_detect(hs), .fixture_detect(fx), .disconnect(dc),
    .connection_detect_out(cd), .hs_boost_active_out(hsb), .boost_enable(ben),
    .boost_level(lvl), .ready(rdy));

  initial forever #50 clk = ~clk;

  // Ceiling is several times the planned run, so only a hang reaches it
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic link(input logic [2:0] k);
    kind = k;
    step(3);
    kind = 3'h0;
    step(1);
  endtask

  // Strap is set while disabled, then the disable is released
  task automatic dis(input int n, input logic [1:0] s);
    chip_disable_n = 1'b0;
    step(n);
    strap = s;
    step(1);
    chip_disable_n = 1'b1;
    w = 0;
    while (rdy !== 1'b1 && w <= umc_pkg::READY_MAX_CYC) begin
      step(1);
      w++;
    end
    chk({2'h0, rdy, w <= umc_pkg::READY_MAX_CYC}, 4'h3);
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    step(12);
    rst = 1'b0;
    step(1);
    chk(stat, 4'h0);
    dis(DIS_CYC + 5, 2'h2);
    chk({2'h0, lvl}, 4'h2);
    chk(stat, 4'h0);
    link(3'h1);
    chk(stat, 4'h4);
    link(3'h5);
    chk(stat, 4'h0);
    link(3'h2);
    chk(stat, 4'h4);
    link(3'h5);
    link(3'h3);
    chk(stat, 4'h7);
    strap = 2'h1;
    step(2);
    chk({2'h0, lvl}, 4'h2);
    chip_disable_n = 1'b0;
    step(5);
    chk(stat, 4'h0);
    chip_disable_n = 1'b1;
    step(3);
    chk(stat, 4'h7);
    chk({2'h0, lvl}, 4'h2);
    dis(DIS_CYC + 5, 2'h1);
    chk(stat, 4'h3);
    chk({2'h0, lvl}, 4'h1);
    link(3'h3);
    chk(stat, 4'h3);
    link(3'h5);
    link(3'h4);
    chk(stat, 4'h3);
    link(3'h5);
    for (int s = 0; s < 4; s++) begin
      dis(DIS_CYC + 5, 2'(s));
      chk({2'h0, lvl}, 4'(s));
      chk(stat, 4'h0);
    end
    // Reset in mid-run with the disable high must still sample the strap
    strap = 2'h1;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(18);
    chk({1'h0, rdy, lvl}, 4'h5);
    chk(stat, 4'h0);
    close_out();
  end
endmodule // umc_mode_ctrl_bench
`default_nettype wire
